// [logic/adc_timing_pkg.sv]
// package: constants, register map and types of the conversion timing block
package adc_timing_pkg;

  // clock rates in kHz; oscillator is synthesised from the system clock
  localparam int unsigned SYS_CLK_KHZ    = 100000;
  localparam int unsigned OSC_NORMAL_KHZ = 1024;
  localparam int unsigned OSC_FAST_KHZ   = 2048;
  localparam int unsigned MOD_DIV        = 4;
  // accumulator steps for half-oscillator-cycle ticks
  localparam logic [17:0] HALF_STEP_NORMAL = 18'(2 * OSC_NORMAL_KHZ);
  localparam logic [17:0] HALF_STEP_FAST   = 18'(2 * OSC_FAST_KHZ);
  localparam logic [17:0] PHASE_WRAP       = 18'(SYS_CLK_KHZ);
  // modulator tick: one per MOD_DIV oscillator cycles, in half ticks
  localparam logic [2:0]  MOD_HALF_LAST    = 3'(2 * MOD_DIV - 1);

  // start delay after latch, in half oscillator cycles (28.5 and 105)
  localparam logic [17:0] START_HALF_NORMAL = 18'h00039;
  localparam logic [17:0] START_HALF_FAST   = 18'h000D2;

  // conversion times in oscillator cycles, index = rate setting
  localparam logic [6:0][16:0] CONT_CYC = {
    17'd1036, 17'd1724, 17'd3116, 17'd5916,
    17'd11532, 17'd22780, 17'd51192};
  localparam logic [6:0][16:0] SS_CYC_NORMAL = {
    17'd1061, 17'd1749, 17'd3141, 17'd5941,
    17'd11557, 17'd22805, 17'd51213};
  localparam logic [6:0][16:0] SS_CYC_FAST = {
    17'd1065, 17'd1753, 17'd3145, 17'd5945,
    17'd11561, 17'd22809, 17'd51217};
  localparam logic [2:0] RATE_MAX = 3'h6;

  // reference settling after switching to the internal source
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned REF_SETTLE_NS     = 25000;
  localparam logic [11:0] REF_SETTLE_CYC =
    12'((REF_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);

  // reference select codes
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_SUPPLY   = 2'h2;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_LATCH  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_DATA   = 8'h14;
  localparam logic [7:0] ADDR_STATE  = 8'h18;

  // field positions
  localparam int unsigned CMD_START_BIT   = 0;
  localparam int unsigned CMD_STOP_BIT    = 1;
  localparam int unsigned STAT_DONE_BIT   = 0;
  localparam int unsigned STAT_SETTLE_BIT = 1;

  // reset values
  localparam logic [6:0] CTRL_RST  = 7'h00;
  localparam logic [7:0] LATCH_RST = 8'h01;
  localparam logic [1:0] IRQ_RST   = 2'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout
  typedef struct packed {
    logic [2:0] rate;
    logic       cont;
    logic       fast;
    logic [1:0] ref_sel;
  } ctrl_t;

  // conversion sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LATCH,
    SEQ_DELAY,
    SEQ_CONVERT
  } seq_state_t;

endpackage : adc_timing_pkg

// [logic/boxcar_decimator.sv]
// boxcar fir decimator: counts modulator ones over one conversion window
module boxcar_decimator #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             sample_en,
  input  wire logic             bit_in,
  input  wire logic             restart,
  input  wire logic             dump,
  output logic [WIDTH-1:0]      word_q,
  output logic                  word_valid_q
);

  logic [WIDTH-1:0] acc_q;   // running sum of the window
  logic [WIDTH-1:0] acc_inc; // sum including this sample
  logic [WIDTH-1:0] acc_d;

  // uniform taps keep the phase linear; window equals the period, so
  // each word depends on this conversion alone and needs no discard
  assign acc_inc = acc_q + WIDTH'(sample_en & bit_in);
  assign acc_d   = (restart | dump) ? '0 : acc_inc;

  // accumulator
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acc_q <= '0;
    else
      acc_q <= acc_d;
  end

  // output word, one valid pulse per window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      word_q       <= '0;
      word_valid_q <= 1'b0;
    end
    else
    begin
      word_valid_q <= dump & ~restart;
      if (dump & ~restart)
        word_q <= acc_inc;
    end
  end

endmodule : boxcar_decimator

// [logic/adc_conversion_timing_control.sv]
// conversion timing and control with axi4-lite registers
module adc_conversion_timing_control #(
  parameter int unsigned DATA_W = 24
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        mod_bit_in,
  output logic             result_ready_n,
  output logic             mod_clk,
  output logic [1:0]       ref_sel,
  output logic             ref_buf_en,
  output logic             fast_mode,
  output logic             irq
);

  // register file
  adc_timing_pkg::ctrl_t ctrl_q;      // mode, rate, reference
  logic [7:0]             latch_q;     // latch delay, oscillator cycles
  logic [1:0]             status_q;    // sticky events
  logic [1:0]             mask_q;      // interrupt enables
  logic [1:0]             status_d;
  // axi state
  logic                   aw_full_q;   // write address held
  logic                   w_full_q;    // write data held
  logic [7:0]             aw_addr_q;
  logic [31:0]            w_data_q;
  logic                   w_strb0_q;   // all fields sit in byte 0
  // timing state
  logic [17:0]            phase_q;     // fractional oscillator phase
  logic [17:0]            phase_sum;
  logic                   half_tick;   // half oscillator cycle
  logic [2:0]             div_q;       // half ticks per modulator cycle
  logic                   mod_tick;
  adc_timing_pkg::seq_state_t state_q;
  logic [17:0]            cnt_q;       // half ticks in current state
  logic [17:0]            cnt_inc;
  logic [17:0]            target;
  logic                   hit;
  // modulator input synchroniser
  logic                   mod_s1_q;
  logic                   mod_s2_q;
  logic                   mod_s3_q;
  logic                   mod_bit_q;
  // reference settling
  logic [11:0]            settle_q;
  logic                   settled_q;
  logic [1:0]             ref_prev_q;
  // filter
  logic [DATA_W-1:0]      word;
  logic                   word_valid;

  // write decode
  wire wr_go   = aw_full_q & w_full_q & ~bvalid;
  wire wr_en   = wr_go & w_strb0_q;
  wire wr_ctrl = wr_en & (aw_addr_q == adc_timing_pkg::ADDR_CTRL);
  wire wr_cmd  = wr_en & (aw_addr_q == adc_timing_pkg::ADDR_CMD);
  wire wr_lat  = wr_en & (aw_addr_q == adc_timing_pkg::ADDR_LATCH);
  wire wr_mask = wr_en & (aw_addr_q == adc_timing_pkg::ADDR_MASK);
  wire wr_hit  = (aw_addr_q == adc_timing_pkg::ADDR_CTRL)
               | (aw_addr_q == adc_timing_pkg::ADDR_CMD)
               | (aw_addr_q == adc_timing_pkg::ADDR_LATCH)
               | (aw_addr_q == adc_timing_pkg::ADDR_STATUS)
               | (aw_addr_q == adc_timing_pkg::ADDR_MASK);
  wire start_cmd = wr_cmd & w_data_q[adc_timing_pkg::CMD_START_BIT];
  wire stop_cmd  = wr_cmd & w_data_q[adc_timing_pkg::CMD_STOP_BIT];

  // read decode, if/else chain
  wire rd_go = arvalid & arready;
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    if (araddr == adc_timing_pkg::ADDR_CTRL)
      rd_word = {25'h0, ctrl_q};
    else if (araddr == adc_timing_pkg::ADDR_CMD)
      rd_word = 32'h0;
    else if (araddr == adc_timing_pkg::ADDR_LATCH)
      rd_word = {24'h0, latch_q};
    else if (araddr == adc_timing_pkg::ADDR_STATUS)
      rd_word = {30'h0, status_q};
    else if (araddr == adc_timing_pkg::ADDR_MASK)
      rd_word = {30'h0, mask_q};
    else if (araddr == adc_timing_pkg::ADDR_DATA)
      rd_word = 32'(word);
    else if (araddr == adc_timing_pkg::ADDR_STATE)
      rd_word = {28'h0, result_ready_n, settled_q, ref_buf_en,
                 state_q != adc_timing_pkg::SEQ_IDLE};
    else
    begin
      rd_word = 32'h0;
      rd_ok   = 1'b0;  // unmapped: slave error
    end
  end
  wire rd_status = rd_go & (araddr == adc_timing_pkg::ADDR_STATUS);

  // axi write channels: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb0_q <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= adc_timing_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid & awready)
      begin
        aw_addr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid & wready)
      begin
        w_data_q  <= wdata;
        w_strb0_q <= wstrb[0];
        w_full_q  <= 1'b1;
        wready    <= 1'b0;
      end
      if (wr_go)
      begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? adc_timing_pkg::RESP_OKAY
                            : adc_timing_pkg::RESP_SLVERR;
      end
      else if (bvalid & bready)
      begin
        // next write only after the response is gone
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // axi read channel: data one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= adc_timing_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_ok ? adc_timing_pkg::RESP_OKAY
                       : adc_timing_pkg::RESP_SLVERR;
    end
    else if (rvalid & rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q  <= adc_timing_pkg::CTRL_RST;
      latch_q <= adc_timing_pkg::LATCH_RST;
      mask_q  <= adc_timing_pkg::IRQ_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= w_data_q[6:0];
      if (wr_lat)
        latch_q <= w_data_q[7:0];  // in oscillator cycles
      if (wr_mask)
        mask_q <= w_data_q[1:0];
    end
  end

  // reference outputs: buffers only serve the external pair
  wire ext_sel = ctrl_q.ref_sel == adc_timing_pkg::REF_EXTERNAL;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_sel    <= adc_timing_pkg::REF_INTERNAL;
      ref_buf_en <= 1'b0;
      fast_mode  <= 1'b0;
    end
    else
    begin
      ref_sel    <= ctrl_q.ref_sel;
      ref_buf_en <= ext_sel;
      fast_mode  <= ctrl_q.fast;
    end
  end

  // reference settling timer, restarted on reset or external->internal;
  // only reported, conversions are not held off (host's duty)
  wire to_internal = (ref_prev_q == adc_timing_pkg::REF_EXTERNAL)
                   & (ctrl_q.ref_sel == adc_timing_pkg::REF_INTERNAL);
  wire settle_evt  = ~settled_q & (settle_q == 12'h001);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_prev_q <= adc_timing_pkg::REF_INTERNAL;
      settle_q   <= adc_timing_pkg::REF_SETTLE_CYC;
      settled_q  <= 1'b0;
    end
    else
    begin
      ref_prev_q <= ctrl_q.ref_sel;
      if (to_internal)
      begin
        settle_q  <= adc_timing_pkg::REF_SETTLE_CYC;
        settled_q <= 1'b0;
      end
      else if (!settled_q)
      begin
        settle_q  <= settle_q - 12'h001;
        settled_q <= settle_evt;
      end
    end
  end

  // oscillator synthesis: fractional phase gives half-cycle ticks at
  // twice the mode's rate, so the modulator clock and sequencer scale with it
  assign phase_sum = phase_q + (ctrl_q.fast ? adc_timing_pkg::HALF_STEP_FAST
                                            : adc_timing_pkg::HALF_STEP_NORMAL);
  assign half_tick = phase_sum >= adc_timing_pkg::PHASE_WRAP;
  assign mod_tick  = half_tick & (div_q == adc_timing_pkg::MOD_HALF_LAST);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 18'h0;
      div_q   <= 3'h0;
      mod_clk <= 1'b0;
    end
    else
    begin
      phase_q <= half_tick ? phase_sum - adc_timing_pkg::PHASE_WRAP
                           : phase_sum;
      if (half_tick)
        div_q <= div_q + 3'h1;
      mod_clk <= div_q[2];  // oscillator / 4
    end
  end

  // modulator bit: three stages, change accepted when stages 2 and 3 agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mod_s1_q  <= 1'b0;
      mod_s2_q  <= 1'b0;
      mod_s3_q  <= 1'b0;
      mod_bit_q <= 1'b0;
    end
    else
    begin
      mod_s1_q <= mod_bit_in;
      mod_s2_q <= mod_s1_q;
      mod_s3_q <= mod_s2_q;
      if (mod_s2_q == mod_s3_q)
        mod_bit_q <= mod_s3_q;
    end
  end

  // sequencer target per state, in half oscillator cycles
  wire [2:0]  rate_sel = (ctrl_q.rate > adc_timing_pkg::RATE_MAX)
                       ? adc_timing_pkg::RATE_MAX : ctrl_q.rate;
  wire [17:0] start_half = ctrl_q.fast ? adc_timing_pkg::START_HALF_FAST
                                       : adc_timing_pkg::START_HALF_NORMAL;
  wire [17:0] cont_half  = {adc_timing_pkg::CONT_CYC[rate_sel], 1'b0};
  wire [17:0] ss_half    = ctrl_q.fast
    ? {adc_timing_pkg::SS_CYC_FAST[rate_sel], 1'b0}
    : {adc_timing_pkg::SS_CYC_NORMAL[rate_sel], 1'b0};
  always_comb
  begin
    case (state_q)
      adc_timing_pkg::SEQ_LATCH:
        target = {9'h0, latch_q, 1'b0};
      adc_timing_pkg::SEQ_DELAY:
        target = start_half;
      adc_timing_pkg::SEQ_CONVERT:
        // single shot counts from latch, so the delay is taken off
        target = ctrl_q.cont ? cont_half
                             : ss_half - start_half;
      default:
        target = 18'h0;
    endcase
  end
  assign cnt_inc = cnt_q + 18'h1;
  assign hit     = half_tick & (cnt_inc >= target);
  wire conv_end  = hit & (state_q == adc_timing_pkg::SEQ_CONVERT);
  wire pre_end   = half_tick & (state_q == adc_timing_pkg::SEQ_CONVERT)
                 & (cnt_inc == target - 18'h2);

  // sequencer: latch wait, start delay, back-to-back conversions
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= adc_timing_pkg::SEQ_IDLE;
      cnt_q   <= 18'h0;
    end
    else if (start_cmd)
    begin
      state_q <= adc_timing_pkg::SEQ_LATCH;
      cnt_q   <= 18'h0;
    end
    else if (stop_cmd)
      state_q <= adc_timing_pkg::SEQ_IDLE;
    else if (hit)
    begin
      cnt_q <= 18'h0;
      case (state_q)
        adc_timing_pkg::SEQ_LATCH:
          state_q <= adc_timing_pkg::SEQ_DELAY;
        adc_timing_pkg::SEQ_DELAY:
          state_q <= adc_timing_pkg::SEQ_CONVERT;
        adc_timing_pkg::SEQ_CONVERT:
          state_q <= ctrl_q.cont ? adc_timing_pkg::SEQ_CONVERT
                                 : adc_timing_pkg::SEQ_IDLE;
        default:
          state_q <= adc_timing_pkg::SEQ_IDLE;
      endcase
    end
    else if (half_tick)
      cnt_q <= cnt_inc;
  end

  // fir decimator over each conversion window
  boxcar_decimator #(
    .WIDTH        (DATA_W)
  ) u_filter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .sample_en    (mod_tick & (state_q == adc_timing_pkg::SEQ_CONVERT)),
    .bit_in       (mod_bit_q),
    .restart      (start_cmd | stop_cmd),
    .dump         (conv_end),
    .word_q       (word),
    .word_valid_q (word_valid)
  );

  // data ready: falls with each word, rises on a start and one
  // oscillator cycle before the next word so every result has an edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      result_ready_n <= 1'b1;
    else if (start_cmd | pre_end)
      result_ready_n <= 1'b1;
    else if (word_valid)
      result_ready_n <= 1'b0;
  end

  // sticky status: event set wins over read clear
  always_comb
  begin
    status_d = rd_status ? 2'h0 : status_q;
    if (word_valid)
      status_d[adc_timing_pkg::STAT_DONE_BIT] = 1'b1;
    if (settle_evt)
      status_d[adc_timing_pkg::STAT_SETTLE_BIT] = 1'b1;
  end

  // status and interrupt line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= adc_timing_pkg::IRQ_RST;
      irq      <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq      <= |(status_d & mask_q);
    end
  end

endmodule : adc_conversion_timing_control

// [verif/mod_source.sv]
// partner model: modulator bit stream stepped by the modulator clock
module mod_source (
  input  wire logic mod_clk,
  input  wire logic ones,
  output logic      bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bit_o = 1'b0;
  // all ones gives a known count; otherwise a toggling stream
  always @(posedge mod_clk)
  begin
    bit_o <= ones ? 1'b1 : ~bit_o;
  end
endmodule : mod_source

// [verif/adc_timing_monitor.sv]
// checker: bus, reference and modulator clock properties at the ports
module adc_timing_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        result_ready_n,
  input wire logic        mod_clk,
  input wire logic [1:0]  ref_sel,
  input wire logic        ref_buf_en,
  input wire logic        fast_mode,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [8:0] gap_q;    // cycles since the last modulator clock edge
  logic       gap_ok_q; // gap began at an edge in the same mode
  logic       mclk_q;   // delayed modulator clock
  logic       fast_q;   // delayed mode bit
  wire        mclk_edge = mod_clk != mclk_q;
  // a mode switch may cut a half period short, so such gaps are skipped
  always_ff @(posedge aclk)
  begin
    mclk_q   <= mod_clk;
    fast_q   <= fast_mode;
    gap_ok_q <= aresetn && fast_mode == fast_q && (mclk_edge || gap_ok_q);
    gap_q    <= (mclk_edge || !aresetn) ? 9'h001 : gap_q + {8'h00, ~&gap_q};
  end
  AST_REF_BUF: assert property (ref_buf_en == (ref_sel == 2'h1))
    else $error("buffer enable does not follow external select");
  AST_RESET_REF: assert property ($rose(aresetn) |->
    ref_sel == 2'h0 && result_ready_n && !irq)
    else $error("wrong state after reset");
  AST_MOD_HALF: assert property (mclk_edge && gap_ok_q |->
    (fast_mode ? gap_q inside {[96:99]} : gap_q inside {[194:197]}))
    else $error("modulator clock half period wrong");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  AST_W_BUSY: assert property (bvalid |-> !awready && !wready)
    else $error("new write taken while response pending");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  AST_MODE_WR: assert property (
    $changed(fast_mode) || $changed(ref_sel) |-> $past(bvalid))
    else $error("mode changed without a write");
  AST_READY_LOW: assert property ($fell(result_ready_n) |=>
    !result_ready_n [*8])
    else $error("ready pulse too short");
  cover property ($fell(result_ready_n));
  cover property (bvalid && bresp == 2'h2);
  cover property ($rose(irq));
endmodule : adc_timing_monitor
bind adc_conversion_timing_control adc_timing_monitor monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .result_ready_n(result_ready_n),
  .mod_clk(mod_clk), .ref_sel(ref_sel), .ref_buf_en(ref_buf_en),
  .fast_mode(fast_mode), .irq(irq));

// [verif/tb.sv]
// testbench: registers, reference select, clocks, interrupt, conversion
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, ref_sel, rsp;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, mod_bit_in;
  logic        result_ready_n, mod_clk, ref_buf_en, fast_mode, irq;
  int          err_total;
  int          checks;
  int          cyc;    // cycles run, for the hang guard
  int          per;    // measured interval minus the expected one, in clock cycles
  integer      seed;
  time         t0;
  adc_conversion_timing_control adc_conversion_timing_control_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mod_bit_in(mod_bit_in), .result_ready_n(result_ready_n),
    .mod_clk(mod_clk), .ref_sel(ref_sel), .ref_buf_en(ref_buf_en),
    .fast_mode(fast_mode), .irq(irq));
  mod_source mod_source_inst (.mod_clk(mod_clk), .ones(1'b1),
    .bit_o(mod_bit_in));
  always #5 aclk = ~aclk;
  // hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw_done;
    logic w_done;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    // each channel let go at the edge that takes it
    do
    begin
      @(posedge aclk);
      aw_done = aw_done | (awready === 1'b1);
      w_done = w_done | (wready === 1'b1);
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    while (!(aw_done && w_done));
    // ready raised late, so the slave must hold its response a cycle
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    // late ready: read data must stand until it is taken
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  // modulator clock period in system cycles, lower bound
  function automatic int exp_period(input logic f);
    return adc_timing_pkg::MOD_DIV * adc_timing_pkg::SYS_CLK_KHZ /
      (f ? adc_timing_pkg::OSC_FAST_KHZ : adc_timing_pkg::OSC_NORMAL_KHZ);
  endfunction : exp_period
  // single shot, fast, rate 6: latch wait plus conversion time
  function automatic int exp_conv();
    return (32'(adc_timing_pkg::LATCH_RST) + adc_timing_pkg::SS_CYC_FAST[6])
      * adc_timing_pkg::SYS_CLK_KHZ / adc_timing_pkg::OSC_FAST_KHZ;
  endfunction : exp_conv
  initial
  begin
    seed = 32'h6e1df0a3;
    {err_total, checks, cyc} = '0;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped and read-only places
    axr(adc_timing_pkg::ADDR_CTRL, rd, rsp);
    `CHK("ctrl", 32'h0, rd)
    `CHK("ref_sel", 2'h0, ref_sel)
    axr(adc_timing_pkg::ADDR_LATCH, rd, rsp);
    `CHK("latch", 32'h1, rd)
    axr(8'h1C, rd, rsp);
    `CHK("unmapped", 34'h200000000, {rsp, rd})
    axw(adc_timing_pkg::ADDR_DATA, $random(seed), rsp);
    `CHK("data write", 2'h2, rsp)
    $display("test registers done");
    // every reference code, random mode bit
    for (int i = 0; i < 4; i++)
    begin
      rd = ($random(seed) & 32'h4) | i;
      axw(adc_timing_pkg::ADDR_CTRL, rd, rsp);
      @(posedge aclk);
      `CHK("ref_sel", rd[1:0], ref_sel)
      `CHK("ref_buf_en", (i == 1), ref_buf_en)
      `CHK("fast_mode", rd[2], fast_mode)
    end
    $display("test reference done");
    // modulator clock in both modes
    for (int f = 0; f < 2; f++)
    begin
      axw(adc_timing_pkg::ADDR_CTRL, 32'(f) << 2, rsp);
      repeat (400) @(posedge aclk);
      @(posedge mod_clk);
      t0 = $time;
      @(posedge mod_clk);
      per = int'(($time - t0) / 10) - exp_period(f[0]);
      `CHK("mod period", 1'b1, per inside {[0:1]})
    end
    $display("test modulator clock done");
    // settled flag raises, then read clears, the interrupt
    repeat (2600) @(posedge aclk);
    axw(adc_timing_pkg::ADDR_MASK, 32'h2, rsp);
    repeat (2) @(posedge aclk);
    `CHK("irq set", 1'b1, irq)
    axr(adc_timing_pkg::ADDR_STATUS, rd, rsp);
    `CHK("status", 32'h2, rd)
    repeat (2) @(posedge aclk);
    `CHK("irq clear", 1'b0, irq)
    $display("test interrupt done");
    // single shot fast rate 6, restarted during the start delay
    axw(adc_timing_pkg::ADDR_MASK, 32'h1, rsp);
    axw(adc_timing_pkg::ADDR_CTRL, 32'h64, rsp);
    axw(adc_timing_pkg::ADDR_CMD, 32'h1, rsp);
    repeat (1000 + ($random(seed) & 32'hFF)) @(posedge aclk);
    `CHK("ready idle", 1'b1, result_ready_n)
    axw(adc_timing_pkg::ADDR_CMD, 32'h1, rsp);
    t0 = $time;
    while (result_ready_n !== 1'b0) @(posedge aclk);
    // the start lands anywhere inside a half oscillator tick, so the
    // count may run short by up to that much
    per = int'(($time - t0) / 10) + 28 - exp_conv();
    `CHK("conv", 1'b1, per inside {[0:36]})
    repeat (2) @(posedge aclk);
    `CHK("irq done", 1'b1, irq)
    axr(adc_timing_pkg::ADDR_STATUS, rd, rsp);
    `CHK("done bit", 1'b1, rd[0])
    axr(adc_timing_pkg::ADDR_DATA, rd, rsp);
    `CHK("ones", 1'b1, rd >= 32'd236 && rd <= 32'd244)
    // start raises ready and busy, stop drops busy again
    axw(adc_timing_pkg::ADDR_CMD, 32'h1, rsp);
    axr(adc_timing_pkg::ADDR_STATE, rd, rsp);
    `CHK("state busy", 4'hD, rd[3:0])
    axw(adc_timing_pkg::ADDR_CMD, 32'h2, rsp);
    axr(adc_timing_pkg::ADDR_STATE, rd, rsp);
    `CHK("state idle", 4'hC, rd[3:0])
    $display("test conversion done");
    give_verdict();
  end
endmodule : tb
